// *** comms_rail_ctrl_fault_logic.sv ***
// Core buck rail control register and boost rail fault logic
`timescale 1ns/1ps
module comms_rail_ctrl_fault_logic (
	input wire logic mclk, // System clock, 100 MHz
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic regWrEn, // Register write strobe from serial controller
	input wire logic regRdEn, // Register read strobe from serial controller
	input wire logic [7:0] regAddr, // Register address
	input wire logic [7:0] regWrData, // Write data
	output logic [7:0] regRdData, // Read data, zero for other addresses
	input wire logic exitStandbyPin, // exit_standby_pin, asynchronous
	input wire logic coreOverCurrentPin, // Core rail over-current comparator
	input wire logic boostEnablePin, // Boost rail enable level
	input wire logic boostSteadyPin, // Boost feedback steady comparator
	input wire logic boostUnderVoltPin, // Boost under-voltage comparator
	input wire logic boostHystPin, // Boost above threshold plus hysteresis
	input wire logic boostOverCurrentPin, // Boost switch over-current comparator
	input wire logic boostShortPin, // Boost short-circuit comparator
	input wire logic boostOverVoltPin, // Boost over-voltage comparator
	input wire logic boostDischargeDisable, // boost_discharge_disable bit
	output logic coreRailOn, // Core rail switching
	output logic corePfmMode, // pulse_frequency_mode
	output logic coreSkipMode, // Automatic pulse skipping
	output logic corePwmMode, // Fixed pulse-width mode
	output logic coreStateReserved, // Reserved state code in use
	output logic coreVolt1v25, // 1.25 V setting selected
	output logic coreVoltLink, // 1.0 V, secondary link sets voltage
	output logic coreCurrentLimit, // Core cycle by cycle current limiting
	output logic boostFaultFlag, // boost_fault_flag
	output logic boostUvCompOn, // Under-voltage comparator enable
	output logic boostSwitchOff, // Boost switch transistor forced off
	output logic boostIsolationOn, // External isolation switch gate
	output logic boostDischargeOn, // Boost discharge FET enable
	output logic regulatorFaultIrq // regulator_fault_interrupt
);
	import rail_ctrl_pkg::*;

	// Decode helper: a state code is usable only with its top bit set
	function automatic logic validCode(input logic [2:0] code);
		return code[2];
	endfunction : validCode

	logic [PIN_W-1:0] pinMeta_r, pinSync_r;
	logic exitPrev_r;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] rdData_r;
	logic railOn_r, pfm_r, skip_r, pwm_r, resv_r, v125_r, vLink_r, coreLim_r, irq_r;
	boost_state_t boostState;
	logic boostFault;

	// Pins arrive from the analog side with no clock relation
	wire [PIN_W-1:0] pinRaw = {boostOverVoltPin, boostShortPin, boostOverCurrentPin,
		boostHystPin, boostUnderVoltPin, boostSteadyPin, coreOverCurrentPin, exitStandbyPin};

	// Two-flop synchroniser; only the second stage is read
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pinMeta_r <= '0;
			pinSync_r <= '0;
			exitPrev_r <= 1'b0;
		end else begin
			pinMeta_r <= pinRaw;
			pinSync_r <= pinMeta_r;
			exitPrev_r <= pinSync_r[0];
		end
	end

	// Enable is a level from the boost control bit; sampled through the same chain style
	logic enMeta_r, enSync_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			enMeta_r <= 1'b0;
			enSync_r <= 1'b0;
		end else begin
			enMeta_r <= boostEnablePin;
			enSync_r <= enMeta_r;
		end
	end

	wire exitSync = pinSync_r[0];
	wire coreOcSync = pinSync_r[1];
	wire exitRise = exitSync && !exitPrev_r;

	// Register field views
	wire [2:0] coreState = ctrl_r[STATE_MSB:STATE_LSB];
	wire [2:0] wakeState = ctrl_r[WAKE_MSB:WAKE_LSB];
	wire [1:0] voltSel = ctrl_r[VSEL_MSB:VSEL_LSB];
	wire ctrlHit = (regAddr == CORE_CTRL_OFS);
	wire ctrlWr = regWrEn && ctrlHit;
	wire wakeCopy = exitRise && validCode(wakeState);

	// Write stores the whole byte; a wake copy in the same edge wins the state field,
	// since the pin event must not be lost behind a racing write
	always_comb begin
		ctrl_nxt = ctrlWr ? regWrData : ctrl_r;
		if (wakeCopy) ctrl_nxt[STATE_MSB:STATE_LSB] = wakeState;
	end

	// Control register and read data
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= CORE_CTRL_RST;
			rdData_r <= 8'h00;
		end else begin
			ctrl_r <= ctrl_nxt;
			rdData_r <= (regRdEn && ctrlHit) ? ctrl_r : 8'h00;
		end
	end

	// Decoded rail controls; reserved codes keep the rail off
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			railOn_r <= 1'b0;
			pfm_r <= 1'b0;
			skip_r <= 1'b0;
			pwm_r <= 1'b0;
			resv_r <= 1'b0;
			v125_r <= 1'b0;
			vLink_r <= 1'b0;
		end else begin
			railOn_r <= validCode(coreState) && (coreState != CORE_ST_OFF);
			pfm_r <= (coreState == CORE_ST_PFM);
			skip_r <= (coreState == CORE_ST_SKIP);
			pwm_r <= (coreState == CORE_ST_PWM);
			resv_r <= !validCode(coreState);
			v125_r <= (voltSel == VSEL_1V25);
			vLink_r <= (voltSel == VSEL_1V0_LINK);
		end
	end

	// Boost sequencer
	boost_fault_seq uBoost (
		.mclk(mclk),
		.rstn(rstn),
		.boostEnable(enSync_r),
		.fbSteady(pinSync_r[2]),
		.underVolt(pinSync_r[3]),
		.aboveHyst(pinSync_r[4]),
		.overCurrent(pinSync_r[5]),
		.shortCircuit(pinSync_r[6]),
		.overVolt(pinSync_r[7]),
		.dischargeDisable(boostDischargeDisable),
		.state(boostState),
		.boostFault(boostFault),
		.uvCompOn(boostUvCompOn),
		.switchOff(boostSwitchOff),
		.isolationOn(boostIsolationOn),
		.dischargeOn(boostDischargeOn)
	);

	// Core current limit and shared interrupt; interrupt lags faults by one edge
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			coreLim_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			coreLim_r <= coreOcSync && railOn_r;
			irq_r <= boostFault || (coreOcSync && railOn_r);
		end
	end

	assign regRdData = rdData_r;
	assign coreRailOn = railOn_r;
	assign corePfmMode = pfm_r;
	assign coreSkipMode = skip_r;
	assign corePwmMode = pwm_r;
	assign coreStateReserved = resv_r;
	assign coreVolt1v25 = v125_r;
	assign coreVoltLink = vLink_r;
	assign coreCurrentLimit = coreLim_r;
	assign boostFaultFlag = boostFault;
	assign regulatorFaultIrq = irq_r;

	// Valid wake code is copied on the pin's rising edge
	a_wake_copy: assert property (@(posedge mclk) disable iff (!rstn)
		wakeCopy |=> coreState == $past(wakeState)) else $error("wake state not copied");
	// Do-not-copy codes leave the state alone
	a_wake_nocopy: assert property (@(posedge mclk) disable iff (!rstn)
		exitRise && !validCode(wakeState) && !ctrlWr |=> $stable(coreState))
		else $error("state changed on no-copy");
	// Register write lands whole when no pin event races it
	a_reg_write: assert property (@(posedge mclk) disable iff (!rstn)
		ctrlWr && !wakeCopy |=> ctrl_r == $past(regWrData)) else $error("write lost");
	// State decode follows one edge later
	a_state_dec: assert property (@(posedge mclk) disable iff (!rstn)
		coreState == CORE_ST_PFM |=> corePfmMode && coreRailOn && !corePwmMode)
		else $error("pfm decode wrong");
	// Skipping mode decodes with PFM off and switches the rail on
	a_skip_dec: assert property (@(posedge mclk) disable iff (!rstn)
		coreState == CORE_ST_SKIP |=> coreSkipMode && coreRailOn && !corePfmMode)
		else $error("skip decode wrong");
	// Reserved codes must never switch the rail; a stray write could otherwise start it
	a_resv_dec: assert property (@(posedge mclk) disable iff (!rstn)
		!validCode(coreState) |=> coreStateReserved && !coreRailOn)
		else $error("reserved decode wrong");
	// Voltage decode
	a_volt_dec: assert property (@(posedge mclk) disable iff (!rstn)
		voltSel == VSEL_1V0_LINK |=> coreVoltLink && !coreVolt1v25) else $error("vsel wrong");
	// Code zero selects the fixed 1.25 V setting
	a_volt_fixed: assert property (@(posedge mclk) disable iff (!rstn)
		voltSel == VSEL_1V25 |=> coreVolt1v25 && !coreVoltLink) else $error("fixed vsel wrong");
	// Boost fault reaches the interrupt
	a_irq_follow: assert property (@(posedge mclk) disable iff (!rstn)
		boostFault |=> regulatorFaultIrq) else $error("irq missing");
	// Core over-current while switching limits current and raises the interrupt
	a_core_limit: assert property (@(posedge mclk) disable iff (!rstn)
		coreOcSync && railOn_r |=> coreCurrentLimit && regulatorFaultIrq)
		else $error("core limit missing");
	// A latched boost trip keeps the shared interrupt up
	a_trip_irq: assert property (@(posedge mclk) disable iff (!rstn)
		boostState == BST_TRIP |=> ##1 regulatorFaultIrq) else $error("trip irq missing");
	c_wake_copy: cover property (@(posedge mclk) disable iff (!rstn) wakeCopy);
	c_irq: cover property (@(posedge mclk) disable iff (!rstn) $rose(regulatorFaultIrq));
endmodule : comms_rail_ctrl_fault_logic

// *** rail_ctrl_pkg.sv ***
// Constants for the comms core rail control register and boost fault logic
package rail_ctrl_pkg;
	// Register map and reset value
	localparam logic [7:0] CORE_CTRL_OFS = 8'h3C;
	localparam logic [7:0] CORE_CTRL_RST = 8'h24;
	// Field positions inside the core rail control register
	localparam int STATE_LSB = 0;
	localparam int STATE_MSB = 2;
	localparam int WAKE_LSB = 3;
	localparam int WAKE_MSB = 5;
	localparam int VSEL_LSB = 6;
	localparam int VSEL_MSB = 7;
	// Core rail state encoding; codes below 3'h4 are reserved
	localparam logic [2:0] CORE_ST_OFF = 3'h4;
	localparam logic [2:0] CORE_ST_PFM = 3'h5;
	localparam logic [2:0] CORE_ST_SKIP = 3'h6;
	localparam logic [2:0] CORE_ST_PWM = 3'h7;
	// Output voltage selection encoding
	localparam logic [1:0] VSEL_1V25 = 2'h0;
	localparam logic [1:0] VSEL_1V0_LINK = 2'h1;
	// Width of the synchronised pin vector
	localparam int PIN_W = 8;
	// Boost sequencer states
	typedef enum logic [1:0] {BST_OFF, BST_RAMP, BST_RUN, BST_TRIP} boost_state_t;
endpackage : rail_ctrl_pkg

// *** boost_fault_seq.sv ***
// Boost rail fault flag sequencer: start-up, under-voltage, over-current, latched trips
`timescale 1ns/1ps
module boost_fault_seq (
	input wire logic mclk, // System clock
	input wire logic rstn, // Asynchronous reset, active low
	input wire logic boostEnable, // Rail enable, already synchronised
	input wire logic fbSteady, // Feedback reached steady state
	input wire logic underVolt, // Output below under-voltage threshold
	input wire logic aboveHyst, // Output above threshold plus hysteresis
	input wire logic overCurrent, // Switch current above limit
	input wire logic shortCircuit, // Feedback below short threshold
	input wire logic overVolt, // Output above over-voltage threshold
	input wire logic dischargeDisable, // boost_discharge_disable bit
	output rail_ctrl_pkg::boost_state_t state, // Sequencer state
	output logic boostFault, // boost_fault_flag
	output logic uvCompOn, // Under-voltage comparator enable
	output logic switchOff, // Switch transistor forced off
	output logic isolationOn, // External isolation switch gate
	output logic dischargeOn // Discharge FET enable
);
	import rail_ctrl_pkg::*;

	boost_state_t state_r, state_nxt;
	logic uv_r, uv_nxt;
	logic oc_r, oc_nxt;
	logic fault_r, fault_nxt;
	logic uvComp_r, swOff_r, iso_r, dsch_r;
	wire running = (state_r == BST_RAMP) || (state_r == BST_RUN);

	// Next state; a trip only clears when the host drops the enable
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			BST_OFF: if (boostEnable) state_nxt = BST_RAMP;
			// Short detection is masked during soft start against inrush current
			BST_RAMP: begin
				if (overVolt) state_nxt = BST_TRIP;
				else if (fbSteady) state_nxt = BST_RUN;
			end
			BST_RUN: if (shortCircuit || overVolt) state_nxt = BST_TRIP;
			BST_TRIP: state_nxt = BST_TRIP;
		endcase
		if (!boostEnable) state_nxt = BST_OFF;
	end

	// Under-voltage sets over clear; the hysteresis keeps it from chattering
	assign uv_nxt = (state_r == BST_RUN) && (underVolt || (uv_r && !aboveHyst));
	// Over-current follows the comparator: clears when current falls back
	assign oc_nxt = running && overCurrent;
	// Fault is the OR of every active source
	assign fault_nxt = (state_r == BST_RAMP) || (state_r == BST_TRIP) || uv_r || oc_r;

	// Sequencer and flag registers
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= BST_OFF;
			uv_r <= 1'b0;
			oc_r <= 1'b0;
			fault_r <= 1'b0;
			uvComp_r <= 1'b0;
			swOff_r <= 1'b1;
			iso_r <= 1'b0;
			dsch_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			uv_r <= uv_nxt;
			oc_r <= oc_nxt;
			fault_r <= fault_nxt;
			uvComp_r <= running;
			swOff_r <= !running || overCurrent;
			iso_r <= running;
			dsch_r <= (state_r == BST_OFF) && !dischargeDisable;
		end
	end

	assign state = state_r;
	assign boostFault = fault_r;
	assign uvCompOn = uvComp_r;
	assign switchOff = swOff_r;
	assign isolationOn = iso_r;
	assign dischargeOn = dsch_r;

	// Enabling the rail raises the fault two edges later
	a_start_fault: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == BST_OFF) && boostEnable |=> ##1 fault_r) else $error("no start fault");
	// Steady feedback without other faults clears the flag
	a_ready_clear: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == BST_RUN) && !uv_r && !oc_r |=> !fault_r) else $error("fault not cleared");
	// Under-voltage shows on the flag
	a_uv_fault: assert property (@(posedge mclk) disable iff (!rstn)
		uv_r |=> fault_r) else $error("uv not flagged");
	// Under-voltage holds until above hysteresis
	a_uv_hold: assert property (@(posedge mclk) disable iff (!rstn)
		uv_r && (state_r == BST_RUN) && !aboveHyst |=> uv_r) else $error("uv cleared early");
	// Over-current forces the switch off next edge, then raises the flag
	a_oc_switch: assert property (@(posedge mclk) disable iff (!rstn)
		running && overCurrent |=> switchOff ##1 fault_r) else $error("oc not handled");
	// Over-current clears once the current falls back
	a_oc_clear: assert property (@(posedge mclk) disable iff (!rstn)
		oc_r && !overCurrent |=> !oc_r) else $error("oc stuck");
	// A trip never restarts while enabled
	a_trip_hold: assert property (@(posedge mclk) disable iff (!rstn)
		(state_r == BST_TRIP) && boostEnable |=> (state_r == BST_TRIP) ##1 fault_r)
		else $error("trip released");
	// Discharge disable keeps the FET off
	a_dsch_block: assert property (@(posedge mclk) disable iff (!rstn)
		dischargeDisable |=> !dischargeOn) else $error("discharge while disabled");
	c_reach_run: cover property (@(posedge mclk) disable iff (!rstn) state_r == BST_RUN);
	c_trip: cover property (@(posedge mclk) disable iff (!rstn) $rose(state_r == BST_TRIP));
endmodule : boost_fault_seq

// *** host_serial_model.sv ***
// Host serial controller model that drives the register port of the rail block
`timescale 1ns/1ps
module host_serial_model import rail_ctrl_pkg::*; (
	input wire logic mclk, // System clock
	input wire logic [7:0] regRdData, // Read data from the block
	output logic regWrEn, // Write strobe
	output logic regRdEn, // Read strobe
	output logic [7:0] regAddr, // Register address
	output logic [7:0] regWrData, // Write data
	output logic boostDischargeDisable // Discharge disable bit
);
	// Idle bus at time zero
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		boostDischargeDisable = 1'b0;
	end
	// One-cycle write; address and data are inverted afterwards so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWrEn <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
	endtask : wr
	// One-cycle read; data is only valid in the cycle after the strobe is taken
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRdEn <= 1'b0;
		regAddr <= ~a;
		#1;
		d = regRdData;
	endtask : rd
	// Without an isolation switch software must keep the discharge FET off
	task automatic set_discharge_disable(input logic v);
		@(posedge mclk);
		boostDischargeDisable <= v;
	endtask : set_discharge_disable
	// Wake state is programmed after power up, before any standby exit
	task automatic power_up(input logic [2:0] wake, input logic [2:0] st);
		wr(CORE_CTRL_OFS, {2'h0, wake, st});
	endtask : power_up
endmodule : host_serial_model

// *** comms_rail_ctrl_fault_logic_tb.sv ***
// Self-checking testbench for the core rail register and boost fault logic
`timescale 1ns/1ps
module comms_rail_ctrl_fault_logic_tb;
	import rail_ctrl_pkg::*;
	logic mclk, rstn, regWrEn, regRdEn, boostDischargeDisable;
	logic [7:0] regAddr, regWrData, regRdData;
	logic exitStandbyPin = 1'b0, coreOverCurrentPin = 1'b0, boostEnablePin = 1'b0;
	logic boostSteadyPin = 1'b0, boostUnderVoltPin = 1'b0, boostHystPin = 1'b0;
	logic boostOverCurrentPin = 1'b0, boostShortPin = 1'b0, boostOverVoltPin = 1'b0;
	logic coreRailOn, corePfmMode, coreSkipMode, corePwmMode, coreStateReserved;
	logic coreVolt1v25, coreVoltLink, coreCurrentLimit, boostFaultFlag, boostUvCompOn;
	logic boostSwitchOff, boostIsolationOn, boostDischargeOn, regulatorFaultIrq;
	int miscompares = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [7:0] d;
	comms_rail_ctrl_fault_logic DUT (.mclk(mclk), .rstn(rstn), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.exitStandbyPin(exitStandbyPin), .coreOverCurrentPin(coreOverCurrentPin),
		.boostEnablePin(boostEnablePin), .boostSteadyPin(boostSteadyPin),
		.boostUnderVoltPin(boostUnderVoltPin), .boostHystPin(boostHystPin),
		.boostOverCurrentPin(boostOverCurrentPin), .boostShortPin(boostShortPin),
		.boostOverVoltPin(boostOverVoltPin), .boostDischargeDisable(boostDischargeDisable),
		.coreRailOn(coreRailOn), .corePfmMode(corePfmMode), .coreSkipMode(coreSkipMode),
		.corePwmMode(corePwmMode), .coreStateReserved(coreStateReserved),
		.coreVolt1v25(coreVolt1v25), .coreVoltLink(coreVoltLink),
		.coreCurrentLimit(coreCurrentLimit), .boostFaultFlag(boostFaultFlag),
		.boostUvCompOn(boostUvCompOn), .boostSwitchOff(boostSwitchOff),
		.boostIsolationOn(boostIsolationOn), .boostDischargeOn(boostDischargeOn),
		.regulatorFaultIrq(regulatorFaultIrq));
	host_serial_model host (.mclk(mclk), .regRdData(regRdData), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
		.boostDischargeDisable(boostDischargeDisable));
	// Free-running 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Hang guard; the full run needs well under two thousand cycles
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			miscompares++;
		end
	endtask : chk
	// Fault flag is behind two sync flops plus state logic, so allow a bounded wait
	task automatic wf(input logic e);
		// Step off the edge so the flag is read once it has settled
		#1;
		for (int i = 0; i < 12 && boostFaultFlag !== e; i++) begin
			@(posedge mclk);
			#1;
		end
		chk(8'(boostFaultFlag), 8'(e));
	endtask : wf
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	task automatic t_reset;
		host.rd(CORE_CTRL_OFS, d);
		chk(d, 8'h24);
		chk(8'({coreRailOn, coreVolt1v25, boostDischargeOn}), 8'h03);
	endtask : t_reset
	// Every state code against every voltage code, then an unmapped address
	task automatic t_states;
		logic [7:0] w;
		for (int v = 0; v < 4; v++) begin
			for (int c = 0; c < 8; c++) begin
				w = {v[1:0], 3'h4, c[2:0]};
				host.wr(CORE_CTRL_OFS, w);
				settle(1);
				chk(8'({coreRailOn, corePfmMode, coreSkipMode, corePwmMode, coreStateReserved}),
					8'({c > 4, c == 5, c == 6, c == 7, c < 4}));
				chk(8'({coreVolt1v25, coreVoltLink}), 8'({v == 0, v == 1}));
				host.rd(CORE_CTRL_OFS, d);
				chk(d, w);
			end
		end
		host.wr(8'h3D, 8'hFF);
		host.rd(8'h3D, d);
		chk(d, 8'h00);
		// The unmapped write is ignored, so the last loop value (code 3, wake 4, PWM) stays
		host.rd(CORE_CTRL_OFS, d);
		chk(d, 8'hE7);
	endtask : t_states
	task automatic pulse_exit;
		@(posedge mclk) exitStandbyPin <= 1'b1;
		repeat (4) @(posedge mclk);
		exitStandbyPin <= 1'b0;
		settle(4);
	endtask : pulse_exit
	// Copy of wake code 7, then a "do not copy" code that must leave the state alone
	task automatic t_wake;
		host.power_up(3'h7, 3'h4);
		pulse_exit();
		host.rd(CORE_CTRL_OFS, d);
		chk(d, 8'h3F);
		chk(8'({corePwmMode, coreRailOn}), 8'h03);
		host.wr(CORE_CTRL_OFS, 8'h15);
		pulse_exit();
		host.rd(CORE_CTRL_OFS, d);
		chk(d, 8'h15);
		chk(8'(corePfmMode), 8'h01);
	endtask : t_wake
	// Core over-current while switching reaches the shared interrupt
	task automatic t_core_oc;
		@(posedge mclk) coreOverCurrentPin <= 1'b1;
		settle(5);
		chk(8'({coreCurrentLimit, regulatorFaultIrq}), 8'h03);
		@(posedge mclk) coreOverCurrentPin <= 1'b0;
		settle(5);
		chk(8'({coreCurrentLimit, regulatorFaultIrq}), 8'h00);
	endtask : t_core_oc
	// Start-up, under-voltage with hysteresis, over-current
	task automatic t_boost;
		@(posedge mclk) boostEnablePin <= 1'b1;
		settle(6);
		chk(8'({boostFaultFlag, boostUvCompOn}), 8'h03);
		@(posedge mclk) boostSteadyPin <= 1'b1;
		boostHystPin <= 1'b1;
		wf(1'b0);
		@(posedge mclk) boostUnderVoltPin <= 1'b1;
		boostHystPin <= 1'b0;
		wf(1'b1);
		settle(2);
		chk(8'(regulatorFaultIrq), 8'h01);
		@(posedge mclk) boostUnderVoltPin <= 1'b0;
		settle(8);
		chk(8'(boostFaultFlag), 8'h01);
		@(posedge mclk) boostHystPin <= 1'b1;
		wf(1'b0);
		@(posedge mclk) boostOverCurrentPin <= 1'b1;
		wf(1'b1);
		settle(2);
		chk(8'(boostSwitchOff), 8'h01);
		@(posedge mclk) boostOverCurrentPin <= 1'b0;
		wf(1'b0);
		settle(2);
		chk(8'(boostSwitchOff), 8'h00);
	endtask : t_boost
	// Short and over-voltage trips latch until the host drops the rail enable
	task automatic t_trip;
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk) boostShortPin <= (i == 0);
			boostOverVoltPin <= (i == 1);
			wf(1'b1);
			@(posedge mclk) boostShortPin <= 1'b0;
			boostOverVoltPin <= 1'b0;
			settle(8);
			chk(8'(boostFaultFlag), 8'h01);
			@(posedge mclk) boostEnablePin <= 1'b0;
			settle(6);
			// The flag is already low while off, so judge it after the restart reaches run
			@(posedge mclk) boostEnablePin <= 1'b1;
			settle(10);
			chk(8'({boostFaultFlag, boostIsolationOn}), 8'h01);
		end
	endtask : t_trip
	task automatic t_discharge;
		@(posedge mclk) boostEnablePin <= 1'b0;
		host.set_discharge_disable(1'b1);
		settle(6);
		chk(8'(boostDischargeOn), 8'h00);
		host.set_discharge_disable(1'b0);
		settle(3);
		chk(8'(boostDischargeOn), 8'h01);
	endtask : t_discharge
	task automatic test_done;
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	// Reset for 16 cycles, then the scenarios in turn
	initial begin
		rstn = 1'b0;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		t_reset();
		t_states();
		t_wake();
		t_core_oc();
		t_boost();
		t_trip();
		t_discharge();
		test_done();
	end
endmodule : comms_rail_ctrl_fault_logic_tb
